/* verilog/see_defines.vh */
// constants for the serial eeprom command engine
`ifndef SEE_DEFINES_VH
`define SEE_DEFINES_VH
`define SEE_OP_STATUS_WRITE_CMD_LOW 3'h1
`define SEE_OP_WRITE    3'h2
`define SEE_OP_READ     3'h3
`define SEE_OP_LATCH_CLEAR_CMD     3'h4
`define SEE_OP_STATUS_READ_CMD     3'h5
`define SEE_OP_LATCH_SET_CMD     3'h6
`define SEE_ST_BUSY     0
`define SEE_ST_LATCH    1
`define SEE_ST_BP_LO    2
`define SEE_ST_BP_HI    3
`define SEE_CLK_HZ      20000000
`define SEE_PROG_MS     5
`define SEE_PROG_CYC    ((`SEE_CLK_HZ / 1000) * `SEE_PROG_MS)
`define SEE_PAGE_BYTES  16
`endif

/* verilog/see_core.v */
// serial eeprom command engine: serial front end, array, status, programming timer
`timescale 1ns/1ps
`include "see_defines.vh"
module see_core #(
	parameter PROG_CYC = `SEE_PROG_CYC
) (
	input  wire       clk_i,
	input  wire       rst_b_i,
	input  wire       cs_b_i,
	input  wire       sck_i,
	input  wire       si_i,
	input  wire       hold_b_i,
	input  wire       wp_b_i,
	output reg        so_o,
	output reg        so_oe_o,
	output wire       busy_o
);
	localparam S_OP = 3'h0, S_ADR = 3'h1, S_RD = 3'h2, S_WR = 3'h3;
	localparam S_SR = 3'h4, S_SW = 3'h5, S_IGN = 3'h6;

	// three-stage synchronisers; second and third must agree before a change counts
	reg [2:0] cs_s, sck_s, si_s, hd_s, wp_s;
	reg       cs_q, sck_q, si_q, hd_q, wp_q;
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cs_s  <= 3'h7;
			sck_s <= 3'h0;
			si_s  <= 3'h0;
			hd_s  <= 3'h7;
			wp_s  <= 3'h7;
			cs_q  <= 1'b1;
			sck_q <= 1'b0;
			si_q  <= 1'b0;
			hd_q  <= 1'b1;
			wp_q  <= 1'b1;
		end
		else
		begin
			cs_s <= {cs_s[1:0], cs_b_i};
			sck_s <= {sck_s[1:0], sck_i};
			si_s <= {si_s[1:0], si_i};
			hd_s <= {hd_s[1:0], hold_b_i};
			wp_s <= {wp_s[1:0], wp_b_i};
			if (cs_s[1] == cs_s[2]) cs_q <= cs_s[2];
			if (sck_s[1] == sck_s[2]) sck_q <= sck_s[2];
			if (si_s[1] == si_s[2]) si_q <= si_s[2];
			if (hd_s[1] == hd_s[2]) hd_q <= hd_s[2];
			if (wp_s[1] == wp_s[2]) wp_q <= wp_s[2];
		end
	end

	// hold gates clock edges and the output enable, so the sequence pauses at the exact bit
	wire sel    = ~cs_q;
	wire run    = sel & hd_q;
	wire sck_n  = sck_s[2];
	wire rise   = run & ~sck_q & sck_n & (sck_s[1] == sck_s[2]);
	wire fall   = run & sck_q & ~sck_n & (sck_s[1] == sck_s[2]);
	wire cs_up  = ~cs_q & cs_s[2] & (cs_s[1] == cs_s[2]);

	reg [7:0] mem [0:255];
	reg [2:0] st_q;
	reg [2:0] bit_q;
	reg [7:0] sh_q, adr_q, tx_q, sr_in_q;
	reg       isw_q, wel_q, bp_lo_q, bp_hi_q, busy_q, latch_set_q;
	reg       commit_q, sw_ok_q;
	reg [3:0] cnt_q;
	reg [7:0] pbase_q;
	reg [7:0] pbuf_q [0:15];
	reg [15:0] pvld_q;
	reg [22:0] tmr_q;
	wire [7:0] shn = {sh_q[6:0], si_q};
	wire [7:0] sr_val = {4'h0, bp_hi_q, bp_lo_q, wel_q, busy_q};
	wire [2:0] opc = shn[2:0];
	wire op_ok = (shn[7:4] == 4'h0);                          // bit 3 ignored
	// protected region check on the page base
	reg prot;
	always @*
	begin
		case ({bp_hi_q, bp_lo_q})
			2'b00: prot = 1'b0;
			2'b01: prot = (pbase_q[7:6] == 2'b11);
			2'b10: prot = pbase_q[7];
			default: prot = 1'b1;
		endcase
	end
	assign busy_o = busy_q;

	// two-entry output buffer: tx_q is the byte on the wire and nxt_q the byte
	// staged behind it, so a sequential read never waits on the array
	reg [7:0] nxt_q;
	integer   k;
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_q        <= S_OP;
			bit_q       <= 3'h0;
			sh_q        <= 8'h00;
			adr_q       <= 8'h00;
			tx_q        <= 8'h00;
			nxt_q       <= 8'h00;
			sr_in_q     <= 8'h00;
			isw_q       <= 1'b0;
			wel_q       <= 1'b0;
			latch_set_q <= 1'b0;
			bp_lo_q     <= 1'b0;
			bp_hi_q     <= 1'b0;
			busy_q      <= 1'b0;
			commit_q    <= 1'b0;
			sw_ok_q     <= 1'b0;
			cnt_q       <= 4'h0;
			pbase_q     <= 8'h00;
			pvld_q      <= 16'h0000;
			tmr_q       <= 23'h000000;
			so_o        <= 1'b0;
			so_oe_o     <= 1'b0;
		end
		else
		begin
			// protect pin low drops the latch at once, whatever the bus is doing
			if (!wp_q)
				wel_q <= 1'b0;

			// programming timer runs on without serial clocks; the array and the
			// protect bits change only at its end, so busy never reads early
			if (busy_q)
			begin
				if (tmr_q == PROG_CYC[22:0] - 23'h1)
				begin
					busy_q <= 1'b0;
					wel_q  <= 1'b0;
					if (isw_q)
					begin
						bp_lo_q <= sr_in_q[`SEE_ST_BP_LO];
						bp_hi_q <= sr_in_q[`SEE_ST_BP_HI];
					end
					else
					begin
						// only slots that were filled are written back
						for (k = 0; k < `SEE_PAGE_BYTES; k = k + 1)
						begin
							if (pvld_q[k])
								mem[{pbase_q[7:4], k[3:0]}] <= pbuf_q[k];
						end
					end
				end
				tmr_q <= tmr_q + 23'h1;
			end

			// enable only in the two answering phases; it drops during hold too
			so_oe_o <= run & (st_q == S_RD || st_q == S_SR);

			// select rise is seen one clock before the deselect below takes effect,
			// so bit_q still tells whether the frame ended on a byte boundary
			if (cs_up)
			begin
				// latch set waits for the end of the frame
				if (latch_set_q && wp_q)
					wel_q <= 1'b1;
				// commit needs whole bytes, latch, protect pin high, a page outside the protected region (status writes skip this), not already busy;
				// a frame cut mid-byte is dropped rather than half written
				if (commit_q && bit_q == 3'h0 && wel_q && wp_q && !busy_q &&
				    (sw_ok_q ? 1'b1 : !prot))
				begin
					busy_q <= 1'b1;
					tmr_q  <= 23'h000000;
					isw_q  <= sw_ok_q;
				end
			end

			if (!sel)
			begin
				// deselected: the command sequence starts over at the next select
				st_q        <= S_OP;
				bit_q       <= 3'h0;
				latch_set_q <= 1'b0;
				commit_q    <= 1'b0;
				sw_ok_q     <= 1'b0;
			end
			else
			begin
				// output moves on the falling serial edge, half a bit ahead of the host
				if (fall)
				begin
					so_o <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end
				// input is taken on the rising serial edge
				if (rise)
				begin
					sh_q  <= shn;
					bit_q <= bit_q + 3'h1;
					// every whole byte is handled by its phase; opcode, address and status write bytes move the phase on
					if (bit_q == 3'h7)
					begin
						case (st_q)
							S_OP:
							begin
								// anything not decoded below parks in the ignore state
								st_q <= S_IGN;
								if (op_ok)
								begin
									// array access is refused while programming
									if (opc == `SEE_OP_READ && !busy_q)
										st_q <= S_ADR;
									if (opc == `SEE_OP_WRITE && !busy_q)
									begin
										st_q   <= S_ADR;
										isw_q  <= 1'b0;
										pvld_q <= 16'h0000;
									end
									// status read is always answered, even while busy
									if (opc == `SEE_OP_STATUS_READ_CMD)
									begin
										st_q <= S_SR;
										tx_q <= sr_val;
									end
									if (opc == `SEE_OP_LATCH_SET_CMD)
										latch_set_q <= 1'b1;
									if (opc == `SEE_OP_LATCH_CLEAR_CMD)
										wel_q <= 1'b0;
									if (opc == `SEE_OP_STATUS_WRITE_CMD_LOW && !busy_q)
										st_q <= S_SW;
									// remember the command for the address phase
									nxt_q <= {5'h00, opc};
								end
							end
							S_ADR:
							begin
								adr_q   <= shn + 8'h01;
								pbase_q <= shn;
								cnt_q   <= shn[3:0];
								if (nxt_q[2:0] == `SEE_OP_READ)
								begin
									// first byte goes straight out, the next one is staged
									st_q  <= S_RD;
									tx_q  <= mem[shn];
									nxt_q <= mem[shn + 8'h01];
								end
								else
								begin
									st_q <= S_WR;
								end
							end
							S_RD:
							begin
								// eight-bit pointer wraps from the top back to zero
								tx_q  <= nxt_q;
								nxt_q <= mem[adr_q + 8'h01];
								adr_q <= adr_q + 8'h01;
							end
							S_WR:
							begin
								// four-bit slot counter wraps inside the page
								pbuf_q[cnt_q] <= shn;
								pvld_q[cnt_q] <= 1'b1;
								cnt_q         <= cnt_q + 4'h1;
								commit_q      <= 1'b1;
							end
							S_SR:
							begin
								// repeated status bytes show the live value
								tx_q <= sr_val;
							end
							S_SW:
							begin
								// new protect bits wait for the programming cycle
								sr_in_q  <= shn;
								sw_ok_q  <= 1'b1;
								commit_q <= 1'b1;
								st_q     <= S_IGN;
							end
							default:
							begin
								st_q <= S_IGN;
							end
						endcase
					end
				end
			end
		end
	end
endmodule // see_core

/* tb/see_core_assertions.sv */
// port checker for the serial eeprom command engine
`timescale 1ns/1ps
module see_core_assertions #(
	parameter int PROG_CYC = 500
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic cs_b_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic so_o,
	input wire logic hold_b_i,
	input wire logic wp_b_i,
	input wire logic so_oe_o,
	input wire logic busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// busy length so far; a counter because the span is far beyond a repetition
	int cnt_q;
	always @(posedge clk_i or negedge rst_b_i)
		cnt_q <= !rst_b_i ? 0 : (busy_o ? cnt_q + 1 : 0);
	a_oe_desel: assert property (cs_b_i [*6] |-> !so_oe_o) else $error("output driven while deselected");
	a_oe_hold: assert property (!hold_b_i [*6] |-> !so_oe_o) else $error("output driven during hold");
	a_oe_framed: assert property ($rose(so_oe_o) |-> !cs_b_i && hold_b_i) else $error("output outside frame");
	a_busy_on_cs: assert property ($rose(busy_o) |-> cs_b_i) else $error("busy before select rose");
	a_busy_wp: assert property ($rose(busy_o) |-> wp_b_i) else $error("write with protect pin low");
	a_busy_quiet: assert property ($rose(busy_o) |-> !so_oe_o) else $error("busy while driving output");
	a_busy_self: assert property ($rose(busy_o) |=> busy_o [*8]) else $error("busy dropped early");
	a_busy_max: assert property (busy_o |-> cnt_q < PROG_CYC) else $error("programming too long");
endmodule // see_core_assertions
bind see_core see_core_assertions #(.PROG_CYC(PROG_CYC)) u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
	.sck_i(sck_i), .si_i(si_i), .so_o(so_o),
	.hold_b_i(hold_b_i), .wp_b_i(wp_b_i), .so_oe_o(so_oe_o), .busy_o(busy_o));

/* tb/see_host.sv */
// host side spi controller model for the eeprom bench
`timescale 1ns/1ps
module see_host (
	input  wire clk_i,
	input  wire so_i,
	input  wire so_oe_i,
	output reg  cs_b_o,
	output reg  sck_o,
	output reg  si_o,
	output reg  hold_b_o
);
	reg last_q; // released line reads as the inverse of its last value
	initial
		{cs_b_o, sck_o, si_o, hold_b_o, last_q} = 5'h12;
	// every pin move lands a fixed delay after a system clock edge
	task tick(input integer n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task sel(input b);
		cs_b_o = b;
		tick(4);
	endtask
	// nb bits of one byte; hold pauses with the clock low before bit hp
	task xfer(input [7:0] d, input integer nb, input integer hp, output [7:0] q);
		for (int i = 0; i < nb; i++)
		begin
			si_o = d[7 - i];
			if (i == hp)
			begin
				hold_b_o = 0;
				tick(8);
				hold_b_o = 1;
			end
			tick(4);
			sck_o = 1;
			tick(4);
			last_q = so_oe_i ? so_i : ~last_q;
			q = {q[6:0], last_q};
			sck_o = 0;
		end
	endtask
endmodule // see_host

/* tb/see_core_tb.sv */
// self-checking bench for the serial eeprom command engine
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module see_core_tb;
	reg         clk_i = 0;
	reg         rst_b_i = 0;
	reg         wp_b_i = 1;
	wire        cs_b, sck, si, hold_b, so, so_oe, busy;
	reg  [7:0]  q;
	reg  [15:0] r;
	integer     num_errors = 0;
	integer     samples_checked = 0;
	always #25 clk_i = ~clk_i;
	see_core #(.PROG_CYC(500)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sck_i(sck), .si_i(si),
		.hold_b_i(hold_b), .wp_b_i(wp_b_i), .so_o(so), .so_oe_o(so_oe), .busy_o(busy));
	see_host host (.clk_i(clk_i), .so_i(so), .so_oe_i(so_oe), .cs_b_o(cs_b), .sck_o(sck), .si_o(si), .hold_b_o(hold_b));
	// one frame of nb bits; the last two answer bytes collect in r
	task frame(input [47:0] d, input integer nb, input integer hp);
		host.sel(0);
		for (int k = 0; 8 * k < nb; k++)
		begin
			host.xfer(d[47 - 8 * k -: 8], (nb - 8 * k > 8) ? 8 : nb - 8 * k, hp - 8 * k, q);
			r = {r[7:0], q};
		end
		host.sel(1);
	endtask
	task op(input [7:0] o);
		frame({o, 40'h0}, 8, -1);
	endtask
	task st(input [7:0] e);
		frame(48'h050000000000, 16, -1);
		`CHK(r[7:0], e)
	endtask
	// status polled while busy, then a bounded wait for the end of programming
	task wr(input [47:0] d, input integer nb, input eb);
		frame(d, nb, -1);
		host.tick(4);
		`CHK(busy, eb)
		if (eb)
		begin
			frame(48'h050000000000, 16, -1);
			`CHK(r[0], 1'b1)
		end
		repeat (1000) if (busy === 1'b1) host.tick(1);
	endtask
	task end_sim;
		$display("checked %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		host.tick(4);
		rst_b_i = 1;
		host.tick(4);
		st(8'h00);
		op(8'h06);
		st(8'h02);
		op(8'h04);
		st(8'h00);
		op(8'h0E);
		op(8'h07);
		st(8'h02);
		op(8'h0C);
		st(8'h00);
		$display("test opcodes done");
		op(8'h06);
		wr({8'h02, 8'hFE, 24'h112233, 8'h00}, 40, 1);
		op(8'h06);
		wr({8'h02, 8'h00, 8'h44, 24'h0}, 24, 1);
		st(8'h00);
		frame({8'h03, 8'hFF, 32'h0}, 32, -1);
		`CHK(r, 16'h2244)
		frame({8'h03, 8'hF0, 32'h0}, 24, -1);
		`CHK(r[7:0], 8'h33)
		frame({8'h03, 8'hFE, 32'h0}, 24, 20);
		`CHK(r[7:0], 8'h11)
		$display("test array done");
		wr({8'h02, 8'h00, 8'h55, 24'h0}, 24, 0);
		op(8'h06);
		wr({8'h02, 8'h00, 8'h99, 24'h0}, 21, 0);
		op(8'h06);
		wp_b_i = 0;
		st(8'h00);
		wr({8'h02, 8'h00, 8'h66, 24'h0}, 24, 0);
		wr({8'h01, 8'h04, 32'h0}, 16, 0);
		wp_b_i = 1;
		frame({8'h03, 8'h00, 32'h0}, 24, -1);
		`CHK(r[7:0], 8'h44)
		$display("test refusal done");
		op(8'h06);
		wr({8'h01, 8'h04, 32'h0}, 16, 1);
		st(8'h04);
		op(8'h06);
		wr({8'h02, 8'hC0, 8'hAA, 24'h0}, 24, 0);
		op(8'h06);
		wr({8'h02, 8'hBF, 8'hBB, 24'h0}, 24, 1);
		op(8'h06);
		wr({8'h01, 8'h00, 32'h0}, 16, 1);
		st(8'h00);
		$display("test protect done");
		end_sim;
	end
	initial
	begin
		#3000000;
		num_errors++;
		end_sim;
	end
endmodule // see_core_tb
